// [rtl/ssq_top.sv]
// eight-bit synchronous serial port sequencer with register port and serial pins
`timescale 1ns/1ps
`default_nettype none
module ssq_top #(
    parameter int SCK_HALF = ssq_pkg::SCK_HALF_CYC
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [ssq_pkg::ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    output logic SO,
    input wire logic SI,
    output logic IRQ
);
    logic order_q, start_q, ext_q;
    logic [1:0] mode_q;
    logic sck_s1_q, sck_s2_q, sck_s3_q, si_s1_q, si_s2_q;
    logic sck_q, oe_q;
    logic [7:0] div_q;
    logic active_q, sef_q, so_q, load_pend_q, irq_arm_q, irq_q;
    logic [2:0] rcnt_q;
    logic [7:0] tsh_q, rsh_q, txbuf_q, rxbuf_q, rdata_q;
    logic txe_q, rxf_q, tx_underrun_flag_q, rx_overrun_flag_q;
    logic wr_ctrl, wr_stat, wr_data, rd_data, abort;
    logic mode_tx, mode_rx, want, run_int;
    logic div_end, fall_ev, rise_ev;
    logic byte_start, tx_load, tx_under, byte_done, rx_done, rx_take;
    logic [7:0] rsh_d;

    assign wr_ctrl = CE && WR && (ADDR == ssq_pkg::OFF_CTRL);
    assign wr_stat = CE && WR && (ADDR == ssq_pkg::OFF_STAT);
    assign wr_data = CE && WR && (ADDR == ssq_pkg::OFF_DATA);
    assign rd_data = CE && RD && (ADDR == ssq_pkg::OFF_DATA);
    assign abort = wr_ctrl && WDATA[ssq_pkg::C_ABORT]; // R16

    assign mode_tx = (mode_q == ssq_pkg::MODE_TX); // R2
    assign mode_rx = (mode_q == ssq_pkg::MODE_RX); // R2

    // internal clock only runs a new byte when there is data to send or room to receive
    assign want = mode_tx ? (!txe_q && !tx_underrun_flag_q) : (mode_rx && !rxf_q && !rx_overrun_flag_q); // R8 R21
    assign run_int = sef_q || (start_q && want); // R11 R12
    assign div_end = (div_q == 8'(SCK_HALF - 1));

    // edges of the serial clock, whichever end makes it
    always_comb begin
        if (ext_q) begin
            fall_ev = CE && sck_s3_q && !sck_s2_q;
            rise_ev = CE && !sck_s3_q && sck_s2_q;
        end else begin
            fall_ev = CE && sck_q && run_int && div_end;
            rise_ev = CE && !sck_q && div_end;
        end
    end

    assign byte_start = fall_ev && !sef_q && start_q && (mode_tx || mode_rx); // R4
    assign tx_load = byte_start && mode_tx && !txe_q && !tx_underrun_flag_q; // R10
    assign tx_under = byte_start && mode_tx && (txe_q || tx_underrun_flag_q); // R13
    assign byte_done = rise_ev && sef_q && (rcnt_q == ssq_pkg::LAST_BIT);
    assign rx_take = rise_ev && sef_q && mode_rx && !rx_overrun_flag_q; // R23
    assign rx_done = byte_done && mode_rx;

    // next receive shifter value, assembled in the selected order
    always_comb begin
        if (order_q) begin
            rsh_d = {si_s2_q, rsh_q[7:1]}; // R1 R18
        end else begin
            rsh_d = {rsh_q[6:0], si_s2_q}; // R1 R18
        end
    end

    // pin synchronisers; the first stage feeds only the second
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
            si_s1_q <= 1'b1;
            si_s2_q <= 1'b1;
        end else if (CE) begin
            sck_s1_q <= SCK_I;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            si_s1_q <= SI;
            si_s2_q <= si_s1_q;
        end
    end

    // control register; abort is a command and is never stored
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            order_q <= 1'b0;
            mode_q <= ssq_pkg::MODE_TX;
            start_q <= 1'b0;
            ext_q <= 1'b0;
        end else if (wr_ctrl) begin
            order_q <= WDATA[ssq_pkg::C_ORDER];
            mode_q <= WDATA[ssq_pkg::C_MODE_HI:ssq_pkg::C_MODE_LO];
            start_q <= WDATA[ssq_pkg::C_START] && !abort; // R16
            ext_q <= WDATA[ssq_pkg::C_EXTCLK];
        end
    end

    // internal serial clock divider; parks high while idle or waiting
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sck_q <= 1'b1;
            div_q <= 8'h00;
            oe_q <= 1'b0;
        end else if (CE) begin
            oe_q <= !ext_q;
            if (ext_q || abort) begin
                sck_q <= 1'b1; // R16 R25
                div_q <= 8'h00;
            end else if (sck_q && !run_int) begin
                div_q <= 8'h00; // R11 R21 R25
            end else if (div_end) begin
                div_q <= 8'h00;
                sck_q <= !sck_q; // R9
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end

    // byte framing: active and shift flags, bit count
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            active_q <= 1'b0;
            sef_q <= 1'b0;
            rcnt_q <= 3'h0;
        end else if (abort) begin
            active_q <= 1'b0; // R16
            sef_q <= 1'b0;
            rcnt_q <= 3'h0;
        end else if (CE) begin
            if (byte_start) begin
                active_q <= 1'b1; // R4
                sef_q <= 1'b1; // R6
                rcnt_q <= 3'h0;
            end else if (byte_done) begin
                sef_q <= 1'b0; // R6
            end else if (rise_ev && sef_q) begin
                rcnt_q <= rcnt_q + 3'h1;
            end
            // stop only between bytes, so a byte in flight always completes
            if (!byte_start && active_q && !sef_q && !start_q) begin
                active_q <= 1'b0; // R14
            end
        end
    end

    // transmit shifter and serial output
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            so_q <= 1'b1;
            tsh_q <= ssq_pkg::BUF_RST;
        end else if (abort) begin
            so_q <= 1'b1;
            tsh_q <= ssq_pkg::BUF_RST;
        end else if (CE) begin
            if (tx_underrun_flag_q || tx_under) begin
                so_q <= 1'b1; // R17
            end else if (tx_load) begin
                so_q <= order_q ? txbuf_q[0] : txbuf_q[7]; // R1 R5
                tsh_q <= order_q ? {1'b0, txbuf_q[7:1]} : {txbuf_q[6:0], 1'b0};
            end else if (fall_ev && sef_q && mode_tx) begin
                so_q <= order_q ? tsh_q[0] : tsh_q[7]; // R5 R12
                tsh_q <= order_q ? {1'b0, tsh_q[7:1]} : {tsh_q[6:0], 1'b0};
            end else if (!active_q || !mode_tx) begin
                so_q <= 1'b1; // R14
            end
        end
    end

    // transmit buffer and its empty flag
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            txbuf_q <= ssq_pkg::BUF_RST;
            txe_q <= 1'b1;
            load_pend_q <= 1'b0;
        end else if (abort) begin
            txbuf_q <= ssq_pkg::BUF_RST; // R16
            txe_q <= 1'b1;
            load_pend_q <= 1'b0;
        end else if (CE) begin
            // a write while the buffer is still full is dropped
            if (wr_data && txe_q) begin
                txbuf_q <= WDATA;
                txe_q <= 1'b0; // R3
            end else if (rise_ev && load_pend_q) begin
                txe_q <= 1'b1; // R7
            end
            if (tx_load) begin
                load_pend_q <= 1'b1;
            end else if (rise_ev) begin
                load_pend_q <= 1'b0;
            end
        end
    end

    // receive shifter, buffer and full flag
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rsh_q <= ssq_pkg::BUF_RST;
            rxbuf_q <= ssq_pkg::BUF_RST;
            rxf_q <= 1'b0;
        end else if (abort) begin
            rsh_q <= ssq_pkg::BUF_RST; // R16
            rxbuf_q <= ssq_pkg::BUF_RST;
            rxf_q <= 1'b0;
        end else if (CE) begin
            if (rx_take) begin
                rsh_q <= rsh_d; // R18 R23
            end
            if (rx_done && !rx_overrun_flag_q && !rxf_q) begin
                rxbuf_q <= rsh_d; // R19
                rxf_q <= 1'b1; // R19
            end else if (rd_data) begin
                rxf_q <= 1'b0; // R20
            end
        end
    end

    // error flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            tx_underrun_flag_q <= 1'b0;
            rx_overrun_flag_q <= 1'b0;
        end else if (abort) begin
            tx_underrun_flag_q <= 1'b0; // R16 R17
            rx_overrun_flag_q <= 1'b0;
        end else if (CE) begin
            if (tx_under) begin
                tx_underrun_flag_q <= 1'b1; // R13
            end else if (wr_stat && !WDATA[ssq_pkg::S_TX_UNDERRUN_FLAG]) begin
                tx_underrun_flag_q <= 1'b0; // R24
            end
            if (rx_done && rxf_q && !rx_overrun_flag_q) begin
                rx_overrun_flag_q <= 1'b1; // R22
            end else if (wr_stat && !WDATA[ssq_pkg::S_RX_OVERRUN_FLAG]) begin
                rx_overrun_flag_q <= 1'b0; // R24
            end
        end
    end

    // serial interrupt: one-cycle pulse
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            irq_arm_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (abort) begin
            irq_arm_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (CE) begin
            irq_q <= (fall_ev && irq_arm_q) || (rx_done && !rx_overrun_flag_q); // R7 R19 R22
            if (tx_under || (rise_ev && load_pend_q)) begin
                irq_arm_q <= 1'b1; // R7 R13
            end else if (fall_ev) begin
                irq_arm_q <= 1'b0;
            end
        end else begin
            irq_q <= 1'b0;
        end
    end

    // register read port, data valid in the cycle after the strobe
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else if (CE && RD) begin
            unique case (ADDR)
                ssq_pkg::OFF_CTRL: rdata_q <= {2'h0, ext_q, 1'b0, start_q, mode_q, order_q};
                ssq_pkg::OFF_STAT: rdata_q <= {2'h0, rx_overrun_flag_q, tx_underrun_flag_q, rxf_q, txe_q, sef_q,
                    active_q};
                ssq_pkg::OFF_DATA: rdata_q <= rxbuf_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign RDATA = rdata_q;
    assign SCK_O = sck_q;
    assign SCK_OE = oe_q;
    assign SO = so_q;
    assign IRQ = irq_q;

    txe_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
        (wr_data && txe_q && !abort) |=> !txe_q)
        else $error("tx buffer write did not clear empty flag");

    abort_stop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R16
        abort |=> (!active_q && !sef_q && !start_q && txe_q && !rxf_q && rxbuf_q == 8'h00))
        else $error("abort did not reset the port");

    active_fall_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
        $rose(active_q) |-> $past(fall_ev))
        else $error("active flag rose without a falling edge");

    underrun_high_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R17
        (tx_underrun_flag_q && $past(tx_underrun_flag_q)) |-> SO)
        else $error("serial output low during underrun");

    rx_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R20
        (rd_data && !rx_done) |=> !rxf_q)
        else $error("rx buffer read did not clear full flag");

    rx_done_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R19
        (rx_done && !rxf_q && !rx_overrun_flag_q && !abort) |=> (rxf_q && IRQ && rxbuf_q == $past(rsh_d)))
        else $error("received byte not delivered");

    overrun_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R22
        (rx_done && rxf_q && !rx_overrun_flag_q && !abort) |=> (rx_overrun_flag_q && IRQ))
        else $error("overrun not flagged");

    overrun_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R23
        (rx_overrun_flag_q && !abort) |=> $stable(rsh_q))
        else $error("shifter changed during overrun");

    sck_idle_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R25
        (!ext_q && !sef_q && !active_q && $past(!sef_q)) |-> SCK_O)
        else $error("internal clock not parked high");

    err_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R24
        (wr_stat && WDATA[ssq_pkg::S_TX_UNDERRUN_FLAG] && tx_underrun_flag_q) |=> tx_underrun_flag_q)
        else $error("writing one cleared the underrun flag");
endmodule
`default_nettype wire

// [rtl/ssq_pkg.sv]
// constants for the synchronous serial transmit/receive sequencer
// How it works
// R1 - bit order select 0 shifts bit 7 first, 1 shifts bit 0 first, both directions
// R2 - transfer mode field 00 selects transmit, 01 selects receive
// R3 - writing the transmit buffer clears the transmit-buffer-empty flag
// R4 - after start, transfer-active flag rises on a serial clock falling edge
// R5 - transmit drives each data bit on serial clock falling edges in chosen order
// R6 - shift-in-progress flag is high from first falling edge through the byte
// R7 - buffer empty sets on rising edge after load; interrupt on the next falling edge
// R8 - internal clock: start alone does not transmit; a buffered byte is needed
// R9 - internal clock: load and clock output begin within one serial clock period
// R10 - external clock: buffer loads on the first incoming falling edge after start
// R11 - internal clock: clock parks high when no new byte; resumes after a write
// R12 - byte written during current byte follows directly without a gap
// R13 - external clock: shift start with empty buffer sets underrun, interrupt next fall
// R14 - clearing start finishes the current byte, drops active flag, output high
// R15 - external clock: peer side must clear start before the next byte begins
// R16 - abort stops at once and resets start, status, receive and transmit buffers
// R17 - serial output stays high while underrun is set; only abort recovers; the code also clears the flag on a status write of 0
// R18 - receive samples serial input on rising edges in the chosen bit order
// R19 - after eight bits the byte goes to the receive buffer, full flag, interrupt
// R20 - reading the receive buffer clears the receive-buffer-full flag
// R21 - internal clock: clock parks after each received byte until buffer is read
// R22 - external clock: unread buffer at byte end sets overrun, then interrupt
// R23 - while overrun is set incoming data is dropped, buffer and shifter kept
// R24 - writing 0 clears an error flag, 1 is ignored; stopping does not clear them
// R25 - internal clock: serial clock line stays high before and after transfers
package ssq_pkg;
    localparam int ADDR_W = 2;
    localparam logic [1:0] OFF_CTRL = 2'h0;
    localparam logic [1:0] OFF_STAT = 2'h1;
    localparam logic [1:0] OFF_DATA = 2'h2;
    localparam int C_ORDER = 0;
    localparam int C_MODE_LO = 1;
    localparam int C_MODE_HI = 2;
    localparam int C_START = 3;
    localparam int C_ABORT = 4;
    localparam int C_EXTCLK = 5;
    localparam int S_ACTIVE = 0;
    localparam int S_SHIFT = 1;
    localparam int S_TXE = 2;
    localparam int S_RXF = 3;
    localparam int S_TX_UNDERRUN_FLAG = 4;
    localparam int S_RX_OVERRUN_FLAG = 5;
    localparam logic [1:0] MODE_TX = 2'h0;
    localparam logic [1:0] MODE_RX = 2'h1;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int SCK_HALF_CYC = 4;
endpackage

// [bench/ssq_peer.sv]
// serial peer model: follows or makes the serial clock, sends one byte and captures one
`timescale 1ns/1ps
`default_nettype none
module ssq_peer (
    input wire logic sck,
    input wire logic so,
    input wire logic lsb_first,
    input wire logic [7:0] tx_byte,
    output logic si,
    output logic sck_drv,
    output logic [7:0] rx_byte
);
    int n_rise = 0;
    logic [2:0] fall_idx = 3'h0;
    logic [2:0] rise_idx = 3'h0;
    initial begin
        si = 1'b1;
        sck_drv = 1'b1;
        rx_byte = 8'h00;
    end
    task automatic restart();
        fall_idx = 3'h0;
        rise_idx = 3'h0;
    endtask
    // clock stands high between frames; 200 ns period keeps each level at 4 core cycles
    // the short lead-in keeps every link edge off a core clock edge, so sampling is not a race
    task automatic ext_byte();
        #7;
        repeat (8) begin
            #100 sck_drv = 1'b0;
            #100 sck_drv = 1'b1;
        end
        #100;
    endtask
    always @(negedge sck) begin
        si <= tx_byte[lsb_first ? fall_idx : 3'h7 - fall_idx];
        fall_idx <= fall_idx + 3'h1;
    end
    always @(posedge sck) begin
        rx_byte <= lsb_first ? {so, rx_byte[7:1]} : {rx_byte[6:0], so};
        n_rise <= n_rise + 1;
        rise_idx <= rise_idx + 3'h1;
        // past the last bit the line carries no data; late so the final sample is not disturbed
        if (rise_idx == 3'h7) si <= #60 ~si;
    end
endmodule
`default_nettype wire

// [bench/ssq_top_bench.sv]
// self-checking bench for the serial sequencer
`timescale 1ns/1ps
`default_nettype none
module ssq_top_bench;
    localparam int HALF = 4;
    localparam int PER = 2 * HALF;
    localparam logic [1:0] CT = ssq_pkg::OFF_CTRL;
    localparam logic [1:0] ST = ssq_pkg::OFF_STAT;
    localparam logic [1:0] DT = ssq_pkg::OFF_DATA;
    typedef struct {logic [1:0] m; logic o; logic [7:0] d;} ssq_row_s;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic CE = 1'b1;
    logic [1:0] ADDR = 2'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] RDATA;
    logic SCK_O, SCK_OE, SO, IRQ, peer_sck, peer_si;
    logic lsb = 1'b0;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] peer_rx;
    logic [7:0] v;
    wire logic sck_line = SCK_OE ? SCK_O : peer_sck;
    int err_total = 0;
    int n_tests = 0;
    int irq_n = 0;
    int cyc, r0;
    ssq_row_s rows [4] = '{'{ssq_pkg::MODE_TX, 1'b0, 8'ha3}, '{ssq_pkg::MODE_TX, 1'b1, 8'h3c},
                           '{ssq_pkg::MODE_RX, 1'b0, 8'hc1}, '{ssq_pkg::MODE_RX, 1'b1, 8'h4e}};
    ssq_top #(.SCK_HALF(HALF)) i_ssq_top (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SCK_I(sck_line),
        .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SO(SO), .SI(peer_si), .IRQ(IRQ));
    ssq_peer i_ssq_peer (.sck(sck_line), .so(SO), .lsb_first(lsb), .tx_byte(peer_tx),
        .si(peer_si), .sck_drv(peer_sck), .rx_byte(peer_rx));
    initial begin
        forever #12.5 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        if (IRQ === 1'b1) irq_n++;
    end
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    // read data first stands in the cycle after the strobe and holds until the next read; it is taken mid-cycle there
    task automatic rd(input logic [1:0] a);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        @(negedge REF_CLK);
        v = RDATA;
    endtask
    task automatic ctrl(input logic ext, input logic [1:0] m, input logic o, input logic st);
        wr(CT, {2'h0, ext, 1'b0, st, m, o});
    endtask
    task automatic abort_all();
        wr(CT, 8'h10);
        repeat (4) @(posedge REF_CLK);
        i_ssq_peer.restart();
        irq_n = 0;
    endtask
    task automatic wait_rise(input int n);
        int goal;
        goal = i_ssq_peer.n_rise + n;
        cyc = 0;
        while (i_ssq_peer.n_rise < goal && cyc < 40 * PER * n) begin
            @(posedge REF_CLK);
            cyc++;
        end
        chk({7'h0, i_ssq_peer.n_rise >= goal}, 8'h01);
    endtask
    task automatic idle_check(input int n);
        r0 = i_ssq_peer.n_rise;
        repeat (n) @(posedge REF_CLK);
        chk(8'(i_ssq_peer.n_rise - r0), 8'h00);
    endtask
    initial begin
        #1_000_000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge REF_CLK);
        RST_N <= 1'b1;
        foreach (rows[i]) begin
            abort_all();
            lsb = rows[i].o;
            peer_tx = rows[i].d;
            ctrl(1'b0, rows[i].m, rows[i].o, 1'b1);
            if (rows[i].m == ssq_pkg::MODE_TX) begin
                idle_check(40);
                chk({7'h0, SCK_O}, 8'h01);
                wr(DT, rows[i].d);
                rd(ST);
                chk(v & 8'h04, 8'h00);
            end
            wait_rise(1);
            chk({7'h0, cyc <= PER + 3}, 8'h01);
            wait_rise(3);
            rd(ST);
            chk(v & 8'h03, 8'h03);
            wait_rise(4);
            repeat (3 * PER) @(posedge REF_CLK);
            rd(ST);
            chk(8'(irq_n), 8'h01);
            if (rows[i].m == ssq_pkg::MODE_TX) begin
                chk(peer_rx, rows[i].d);
                chk(v & 8'h0e, 8'h04);
            end else begin
                chk(v & 8'h0e, 8'h0c);
                idle_check(3 * PER);
                rd(DT);
                chk(v, rows[i].d);
                rd(ST);
                chk(v & 8'h08, 8'h00);
                wait_rise(1);
                chk({7'h0, cyc <= 2 * PER}, 8'h01);
            end
        end
        // second byte written once the first is loaded must follow with no gap
        abort_all();
        lsb = 1'b0;
        ctrl(1'b0, ssq_pkg::MODE_TX, 1'b0, 1'b1);
        wr(DT, 8'h96);
        wait_rise(1);
        wr(DT, 8'h0f);
        wait_rise(7);
        chk(peer_rx, 8'h96);
        wait_rise(8);
        chk(8'(cyc), 8'(8 * PER));
        chk(peer_rx, 8'h0f);
        // stop by clearing start in mid-byte: the byte still completes
        wr(DT, 8'hc4);
        wait_rise(2);
        // a low clock enable freezes the serial clock in mid-byte
        CE <= 1'b0;
        idle_check(20);
        CE <= 1'b1;
        ctrl(1'b0, ssq_pkg::MODE_TX, 1'b0, 1'b0);
        wait_rise(6);
        repeat (3 * PER) @(posedge REF_CLK);
        rd(ST);
        chk(v & 8'h01, 8'h00);
        chk({7'h0, SO}, 8'h01);
        chk(peer_rx, 8'hc4);
        wr(DT, 8'h11);
        idle_check(40);
        // abort in mid-receive
        ctrl(1'b0, ssq_pkg::MODE_RX, 1'b0, 1'b1);
        wait_rise(3);
        wr(CT, 8'h10);
        rd(ST);
        chk(v, 8'h04);
        rd(CT);
        chk(v & 8'h18, 8'h00);
        rd(DT);
        chk(v, 8'h00);
        idle_check(40);
        // external clock transmit, then a byte with nothing written
        abort_all();
        lsb = 1'b1;
        ctrl(1'b1, ssq_pkg::MODE_TX, 1'b1, 1'b1);
        wr(DT, 8'h6b);
        repeat (4) @(posedge REF_CLK);
        chk({7'h0, SCK_OE}, 8'h00);
        i_ssq_peer.ext_byte();
        chk(peer_rx, 8'h6b);
        r0 = irq_n;
        i_ssq_peer.ext_byte();
        chk(peer_rx, 8'hff);
        rd(ST);
        chk(v & 8'h10, 8'h10);
        chk({7'h0, irq_n > r0}, 8'h01);
        wr(ST, 8'h10);
        rd(ST);
        chk(v & 8'h10, 8'h10);
        wr(ST, 8'h00);
        rd(ST);
        chk(v & 8'h10, 8'h00);
        // external clock receive left unread
        abort_all();
        lsb = 1'b0;
        peer_tx = 8'h5a;
        ctrl(1'b1, ssq_pkg::MODE_RX, 1'b0, 1'b1);
        repeat (4) @(posedge REF_CLK);
        i_ssq_peer.ext_byte();
        peer_tx = 8'h33;
        i_ssq_peer.ext_byte();
        // a further byte while overrun stands must leave buffer and shifter alone
        peer_tx = 8'hc3;
        i_ssq_peer.ext_byte();
        ctrl(1'b1, ssq_pkg::MODE_RX, 1'b0, 1'b0);
        rd(ST);
        chk(v & 8'h28, 8'h28);
        chk(8'(irq_n), 8'h02);
        rd(DT);
        chk(v, 8'h5a);
        wr(ST, 8'h20);
        rd(ST);
        chk(v & 8'h20, 8'h20);
        wr(ST, 8'h00);
        rd(ST);
        chk(v & 8'h20, 8'h00);
        // a second reset in mid-run
        @(posedge REF_CLK);
        RST_N <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        RST_N <= 1'b1;
        rd(ST);
        chk(v, 8'h04);
        rd(DT);
        chk(v, 8'h00);
        chk({6'h0, SO, SCK_O}, 8'h03);
        give_verdict();
    end
endmodule
`default_nettype wire
